// >>> pwr_seq_pkg.sv
// shared constants for the module power and reset sequencer
package pwr_seq_pkg;

    // clock rate
    localparam int unsigned CLK_HZ            = 100_000_000;

    // long press that forces power-down, seconds
    localparam int unsigned HOLD_OFF_S        = 7;
    localparam longint unsigned HOLD_OFF_CYCLES = longint'(HOLD_OFF_S) * CLK_HZ;

    // button debounce window, in microseconds
    localparam int unsigned DEBOUNCE_US       = 10_000;
    localparam int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_US * (CLK_HZ / 1_000_000);

    // settle time between steps, microseconds
    localparam int unsigned STEP_US           = 1_000;
    localparam int unsigned STEP_CYCLES       = STEP_US * (CLK_HZ / 1_000_000);

    // width of the input synchronisers
    localparam int unsigned SYNC_STAGES       = 2;

    // reset values of the carrier-facing outputs
    localparam logic RST_CARRIER_POWER_ENABLE = 1'b0;
    localparam logic RST_CARRIER_STANDBY_N    = 1'b1;

    typedef enum logic [3:0] {
        ST_OFF        = 4'h0,
        ST_PWR_MODULE = 4'h1,
        ST_PWR_CARRIER = 4'h2,
        ST_RELEASE    = 4'h3,
        ST_ON         = 4'h4,
        ST_SLEEP      = 4'h5,
        ST_DN_RESET   = 4'h6,
        ST_DN_CARRIER = 4'h7,
        ST_DN_MODULE  = 4'h8
    } seq_state_type;

endpackage

// >>> input_sync.sv
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/100ps
module input_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pin and result
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic next_stage1;
    logic next_level;

    always_comb
    begin
        next_stage1 = pin;
        next_level  = stage1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stage1 <= RESET_LEVEL;
            level  <= RESET_LEVEL;
        end
        else
        begin
            stage1 <= next_stage1;
            level  <= next_level;
        end
    end
endmodule

// >>> button_debounce.sv
// debouncer: output follows input once it has been steady for the window
`timescale 1ns/100ps
module button_debounce #(
    parameter int unsigned WINDOW      = 1_000_000,
    parameter logic        RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // synchronised level in, steady level out
    input  wire logic raw,
    output logic      steady
);
    localparam int unsigned CW = $clog2(WINDOW + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_steady;

    always_comb
    begin
        next_count  = count;
        next_steady = steady;
        if (raw == steady)
        begin
            next_count = '0;
        end
        else if (count == CW'(WINDOW - 1))
        begin
            next_count  = '0;
            next_steady = raw;
        end
        else
        begin
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count  <= '0;
            steady <= RESET_LEVEL;
        end
        else
        begin
            count  <= next_count;
            steady <= next_steady;
        end
    end
endmodule

// >>> module_power_reset_control.sv
// power-up, standby and reset sequencer facing the carrier board
//
// Contract
// - no power-up while supply-invalid input low
// - raise carrier power enable when safe
// - power button starts system power-on
// - standby output low only in standby
// - optional charger-present auto power-on
// - sleep request active low, pulled up
// - full-system reset line two-way
// - processor reset line two-way, spares controller
// - primary reset fans to three resets
// - clock-reset controller resets remaining blocks
// - real-time clock stays in always-on domain
// - wake and power requests exit deep sleep
// - sleep keeps states, requests external power; the code drops pmu_power_request while in sleep
// - carrier waits enable, then processor reset released
// - shutdown: reset first, then drop enable
// - only button rising edge turns on; the code also turns on at charger attach when auto_en is set
// - seven second low press powers down
`timescale 1ns/100ps
module module_power_reset_control
#(
    parameter longint unsigned HOLD_CYCLES     = pwr_seq_pkg::HOLD_OFF_CYCLES,
    parameter int unsigned     DEBOUNCE_WINDOW = pwr_seq_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned     STEP_WAIT       = pwr_seq_pkg::STEP_CYCLES,
    parameter int unsigned     WAKE_SOURCES    = 4
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    // carrier sideband inputs, asynchronous
    input  wire logic                    supply_invalid_n,
    input  wire logic                    power_button_n,
    input  wire logic                    charger_present_n,
    input  wire logic                    sleep_request_n,
    // strap: auto power-on from charger present
    input  wire logic                    auto_power_on,
    // full-system reset line, open drain
    input  wire logic                    system_reset_in_n,
    output logic                         system_reset_out,
    output logic                         system_reset_oe,
    // processor and flash reset line, open drain
    input  wire logic                    cpu_reset_in_n,
    output logic                         cpu_reset_out,
    output logic                         cpu_reset_oe,
    // primary chip reset and wake requests, asynchronous
    input  wire logic                    primary_chip_reset_n,
    input  wire logic [WAKE_SOURCES-1:0] wake_request,
    input  wire logic                    power_request,
    input  wire logic                    clock_request,
    // software power commands, same clock
    input  wire logic                    shutdown_request,
    input  wire logic                    sleep_enter,
    // carrier outputs
    output logic                         carrier_power_enable,
    output logic                         carrier_standby_n,
    // external power manager
    output logic                         pmu_power_request,
    // derived resets, active low
    output logic                         power_controller_rst_n,
    output logic                         rtc_rst_n,
    output logic                         clock_reset_controller_rst_n,
    output logic                         soc_blocks_rst_n,
    // state
    output logic                         module_power_on
);
    import pwr_seq_pkg::*;

    localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
    localparam int unsigned SW = $clog2(STEP_WAIT + 1);
    localparam int unsigned NS = 7 + WAKE_SOURCES;

    // two flops on every pin; the line inputs idle high
    logic [NS-1:0] pins;
    logic [NS-1:0] synced;
    assign pins = {wake_request, clock_request, power_request, primary_chip_reset_n,
                   cpu_reset_in_n, system_reset_in_n, sleep_request_n, charger_present_n};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_sync
            input_sync #(
                .RESET_LEVEL (gi < 5 ? 1'b1 : 1'b0)
            ) u_sync (
                .clk_sys (clk_sys),
                .sys_rst (sys_rst),
                .pin     (pins[gi]),
                .level   (synced[gi])
            );
        end
    endgenerate

    logic sup_ok_sync;
    logic btn_sync;
    input_sync #(.RESET_LEVEL(1'b0)) u_sync_sup (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin     (supply_invalid_n),
        .level   (sup_ok_sync)
    );
    input_sync #(.RESET_LEVEL(1'b1)) u_sync_btn (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin     (power_button_n),
        .level   (btn_sync)
    );

    // button-driven inputs are debounced
    logic btn_n;
    logic sysrst_btn_n;
    button_debounce #(.WINDOW(DEBOUNCE_WINDOW), .RESET_LEVEL(1'b1)) u_deb_btn (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .raw     (btn_sync),
        .steady  (btn_n)
    );
    button_debounce #(.WINDOW(DEBOUNCE_WINDOW), .RESET_LEVEL(1'b1)) u_deb_rst (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .raw     (synced[2]),
        .steady  (sysrst_btn_n)
    );

    logic charger_n;
    logic sleep_req_n;
    logic cpu_line_n;
    logic chip_rst_n;
    logic wake_any;
    assign charger_n   = synced[0];
    assign sleep_req_n = synced[1];
    assign cpu_line_n  = synced[3];
    assign chip_rst_n  = synced[4];
    // any request source can end deep sleep
    assign wake_any    = |synced[NS-1:5];

    logic strap_sync;
    logic auto_en;
    logic next_auto_en;
    logic btn_prev;
    input_sync #(.RESET_LEVEL(1'b0)) u_sync_strap (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin     (auto_power_on),
        .level   (strap_sync)
    );
    logic next_btn_prev;
    logic charger_prev_n;
    logic next_charger_prev_n;

    seq_state_type   state;
    seq_state_type   next_state;
    logic [HW-1:0]   hold_cnt;
    logic [HW-1:0]   next_hold_cnt;
    logic [SW-1:0]   step_cnt;
    logic [SW-1:0]   next_step_cnt;
    logic            step_done;
    logic            on_event;
    logic            next_carrier_power_enable;
    logic            next_carrier_standby_n;
    logic            next_cpu_reset;
    logic            next_sys_reset;
    logic            next_pmu_power_request;
    logic            next_module_power_on;
    logic            next_pc_rst_n;
    logic            next_soc_rst_n;
    logic            hold_done;

    assign step_done = (step_cnt == SW'(STEP_WAIT - 1));
    assign hold_done = (hold_cnt == HW'(HOLD_CYCLES - 1));
    // button rise, or charger attach when enabled
    assign on_event  = (btn_n && !btn_prev)
                     || (auto_en && !charger_n && charger_prev_n);

    always_comb
    begin
        next_state = state;
        next_step_cnt = '0;
        next_hold_cnt = '0;
        next_auto_en = strap_sync;
        next_btn_prev = btn_n;
        next_charger_prev_n = charger_n;
        next_carrier_power_enable = carrier_power_enable;
        next_carrier_standby_n = 1'b1;
        next_cpu_reset = cpu_reset_oe;
        next_sys_reset = system_reset_oe;
        next_pmu_power_request = pmu_power_request;
        next_module_power_on = module_power_on;
        unique case (state)
            ST_OFF:
            begin
                next_cpu_reset         = 1'b1;
                next_sys_reset         = 1'b1;
                next_pmu_power_request = 1'b0;
                next_module_power_on   = 1'b0;
                if (sup_ok_sync && on_event)
                begin
                    next_state             = ST_PWR_MODULE;
                    next_pmu_power_request = 1'b1;
                end
            end
            ST_PWR_MODULE:
            begin
                next_step_cnt = step_cnt + SW'(1);
                if (!sup_ok_sync)
                begin
                    next_state             = ST_OFF;
                    next_pmu_power_request = 1'b0;
                end
                else if (step_done)
                begin
                    // module rails settled, carrier may now power
                    next_state                = ST_PWR_CARRIER;
                    next_step_cnt             = '0;
                    next_carrier_power_enable = 1'b1;
                    next_module_power_on      = 1'b1;
                end
            end
            ST_PWR_CARRIER:
            begin
                next_step_cnt = step_cnt + SW'(1);
                if (step_done)
                begin
                    next_state     = ST_RELEASE;
                    next_step_cnt  = '0;
                    next_sys_reset = 1'b0;
                end
            end
            ST_RELEASE:
            begin
                next_step_cnt = step_cnt + SW'(1);
                if (step_done)
                begin
                    next_state     = ST_ON;
                    next_cpu_reset = 1'b0;
                end
            end
            ST_ON:
            begin
                next_hold_cnt = btn_n ? '0 : hold_cnt + HW'(1);
                if (shutdown_request || (!btn_n && hold_done))
                begin
                    next_state     = ST_DN_RESET;
                    next_hold_cnt  = '0;
                    next_cpu_reset = 1'b1;
                    next_sys_reset = 1'b1;
                end
                else if (sleep_enter || !sleep_req_n)
                begin
                    next_state             = ST_SLEEP;
                    next_carrier_standby_n = 1'b0;
                end
            end
            ST_SLEEP:
            begin
                // lines keep their levels; pmu may drop rails
                next_carrier_standby_n = 1'b0;
                next_pmu_power_request = 1'b0;
                if (wake_any || on_event)
                begin
                    next_state             = ST_ON;
                    next_carrier_standby_n = 1'b1;
                    next_pmu_power_request = 1'b1;
                end
            end
            ST_DN_RESET:
            begin
                next_step_cnt = step_cnt + SW'(1);
                if (step_done)
                begin
                    next_state                = ST_DN_CARRIER;
                    next_step_cnt             = '0;
                    next_carrier_power_enable = 1'b0;
                end
            end
            ST_DN_CARRIER:
            begin
                next_step_cnt = step_cnt + SW'(1);
                if (step_done)
                begin
                    next_state             = ST_DN_MODULE;
                    next_step_cnt          = '0;
                    next_pmu_power_request = 1'b0;
                end
            end
            ST_DN_MODULE:
            begin
                next_state = ST_OFF;
            end
            default:
            begin
                next_state = ST_OFF;
            end
        endcase
    end

    // fan-out of the primary reset; sleep never touches it
    always_comb
    begin
        next_pc_rst_n  = chip_rst_n;
        // carrier reset button or cpu line pulls the blocks, not the controller
        next_soc_rst_n = clock_reset_controller_rst_n && sysrst_btn_n
                         && cpu_line_n && !cpu_reset_oe;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= ST_OFF;
            step_cnt <= '0;
            hold_cnt <= '0;
            auto_en <= 1'b0;
            btn_prev <= 1'b1;
            charger_prev_n <= 1'b1;
            carrier_power_enable <= RST_CARRIER_POWER_ENABLE;
            carrier_standby_n <= RST_CARRIER_STANDBY_N;
            cpu_reset_oe <= 1'b1;
            system_reset_oe <= 1'b1;
            pmu_power_request <= 1'b0;
            module_power_on <= 1'b0;
            power_controller_rst_n <= 1'b0;
            rtc_rst_n <= 1'b0;
            clock_reset_controller_rst_n <= 1'b0;
            soc_blocks_rst_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
            step_cnt <= next_step_cnt;
            hold_cnt <= next_hold_cnt;
            auto_en <= next_auto_en;
            btn_prev <= next_btn_prev;
            charger_prev_n <= next_charger_prev_n;
            carrier_power_enable <= next_carrier_power_enable;
            carrier_standby_n <= next_carrier_standby_n;
            cpu_reset_oe <= next_cpu_reset;
            system_reset_oe <= next_sys_reset;
            pmu_power_request <= next_pmu_power_request;
            module_power_on <= next_module_power_on;
            power_controller_rst_n <= next_pc_rst_n;
            rtc_rst_n <= next_pc_rst_n;
            clock_reset_controller_rst_n <= next_pc_rst_n;
            soc_blocks_rst_n <= next_soc_rst_n;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge clk_sys)
    begin
        system_reset_out <= 1'b0;
        cpu_reset_out    <= 1'b0;
    end
endmodule

// >>> carrier_model.sv
// carrier board side: supply monitor, wired reset lines, sleep pull-up
`timescale 1ns/100ps
module carrier_model (
    // clock and supply
    input  wire logic clk_sys,
    input  wire logic supply_stable,
    // carrier-side drives
    input  wire logic reset_button,
    input  wire logic cpu_force,
    input  wire logic sleep_pull,
    // device drives
    input  wire logic system_reset_out,
    input  wire logic system_reset_oe,
    input  wire logic cpu_reset_out,
    input  wire logic cpu_reset_oe,
    input  wire logic carrier_power_enable,
    // levels seen by the device
    output logic      supply_invalid_n,
    output logic      system_reset_in_n,
    output logic      cpu_reset_in_n,
    output logic      sleep_request_n,
    output logic      rails_on
);
    logic [1:0] settle;

    // flag waits for three stable samples, never on the first glitch
    always_ff @(posedge clk_sys)
    begin
        settle <= !supply_stable ? 2'h0 : (settle == 2'h3 ? settle : settle + 2'h1);
    end
    assign supply_invalid_n  = supply_stable && settle == 2'h3;
    // pulled-up lines, low while any party pulls
    assign system_reset_in_n = !((system_reset_oe && !system_reset_out) || reset_button);
    assign cpu_reset_in_n    = !((cpu_reset_oe && !cpu_reset_out) || cpu_force);
    assign sleep_request_n   = !sleep_pull;
    // carrier rails never lead the enable
    assign rails_on          = carrier_power_enable;
endmodule

// >>> pwr_seq_asserts.sv
// assertions on the ports of the power and reset sequencer
`timescale 1ns/100ps
module pwr_seq_chk #(
    parameter longint unsigned HOLD_CYCLES = 200
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // inputs watched
    input wire logic supply_invalid_n,
    input wire logic power_button_n,
    input wire logic primary_chip_reset_n,
    // reset lines
    input wire logic system_reset_out,
    input wire logic system_reset_oe,
    input wire logic cpu_reset_out,
    input wire logic cpu_reset_oe,
    // carrier and power
    input wire logic carrier_power_enable,
    input wire logic carrier_standby_n,
    input wire logic pmu_power_request,
    input wire logic module_power_on,
    // derived resets
    input wire logic power_controller_rst_n,
    input wire logic rtc_rst_n,
    input wire logic clock_reset_controller_rst_n,
    input wire logic soc_blocks_rst_n
);
    logic [31:0] press_cnt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // raw low time while on; 32 bits outlast any run
    always_ff @(posedge clk_sys)
    begin
        press_cnt <= (sys_rst || power_button_n || !module_power_on) ? 32'h0 : press_cnt + 32'h1;
    end

    fanout_equal_a: assert property (power_controller_rst_n == rtc_rst_n &&
        rtc_rst_n == clock_reset_controller_rst_n) else $error("fanout differs");
    primary_fan_a: assert property (!primary_chip_reset_n [*5] |->
        !power_controller_rst_n) else $error("primary lost");
    soc_follow_a: assert property (!clock_reset_controller_rst_n [*2] |->
        !soc_blocks_rst_n) else $error("block reset");
    cpu_hold_a: assert property (cpu_reset_oe [*2] |-> !soc_blocks_rst_n)
        else $error("cpu reset ignored");
    od_data_a: assert property (!system_reset_out && !cpu_reset_out)
        else $error("line driven high");
    standby_on_a: assert property (!carrier_standby_n |-> module_power_on && !cpu_reset_oe)
        else $error("bad standby");
    sleep_hold_a: assert property (!carrier_standby_n |-> carrier_power_enable &&
        $stable(carrier_power_enable)) else $error("sleep enable");
    enable_after_a: assert property ($rose(carrier_power_enable) |->
        $past(pmu_power_request, 8) && system_reset_oe) else $error("early enable");
    release_order_a: assert property ($fell(cpu_reset_oe) |-> carrier_power_enable &&
        $past(system_reset_oe, 7) == 1'b0) else $error("early release");
    shutdown_order_a: assert property ($fell(carrier_power_enable) |->
        cpu_reset_oe && $past(cpu_reset_oe, 7)) else $error("early drop");
    supply_gate_a: assert property ($rose(pmu_power_request) && !module_power_on |->
        $past(supply_invalid_n, 3)) else $error("bad supply on");
    long_press_a: assert property (press_cnt == 32'(HOLD_CYCLES + 16) |->
        system_reset_oe && cpu_reset_oe) else $error("long press");

    cover property ($rose(carrier_power_enable));
    cover property ($fell(carrier_standby_n));
    cover property ($fell(module_power_on));
endmodule

bind module_power_reset_control pwr_seq_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .clk_sys, .sys_rst, .supply_invalid_n, .power_button_n, .primary_chip_reset_n,
    .system_reset_out, .system_reset_oe, .cpu_reset_out, .cpu_reset_oe,
    .carrier_power_enable, .carrier_standby_n, .pmu_power_request, .module_power_on,
    .power_controller_rst_n, .rtc_rst_n, .clock_reset_controller_rst_n, .soc_blocks_rst_n);

// >>> module_power_reset_control_tb.sv
// self-checking bench for the power and reset sequencer
`timescale 1ns/100ps
module module_power_reset_control_tb;
    // short counts keep the run brief
    localparam longint unsigned HOLD = 200;
    localparam int unsigned     STEP = 8;
    logic       clk_sys, sys_rst, supply_stable, reset_button, cpu_force, sleep_pull;
    logic       power_button_n, charger_present_n, auto_power_on, primary_chip_reset_n;
    logic [3:0] wake_request;
    logic       power_request, clock_request, shutdown_request, sleep_enter;
    logic       supply_invalid_n, sleep_request_n, system_reset_in_n, cpu_reset_in_n;
    logic       system_reset_out, system_reset_oe, cpu_reset_out, cpu_reset_oe;
    logic       carrier_power_enable, carrier_standby_n, pmu_power_request, rails_on;
    logic       power_controller_rst_n, rtc_rst_n, clock_reset_controller_rst_n;
    logic       soc_blocks_rst_n, module_power_on;
    int         miscompares, comparisons, waited;

    module_power_reset_control #(.HOLD_CYCLES(HOLD), .DEBOUNCE_WINDOW(4), .STEP_WAIT(STEP),
        .WAKE_SOURCES(4)) dut_u (
        .clk_sys, .sys_rst, .supply_invalid_n, .power_button_n, .charger_present_n,
        .sleep_request_n, .auto_power_on, .system_reset_in_n, .system_reset_out,
        .system_reset_oe, .cpu_reset_in_n, .cpu_reset_out, .cpu_reset_oe,
        .primary_chip_reset_n, .wake_request, .power_request, .clock_request,
        .shutdown_request, .sleep_enter, .carrier_power_enable, .carrier_standby_n,
        .pmu_power_request, .power_controller_rst_n, .rtc_rst_n,
        .clock_reset_controller_rst_n, .soc_blocks_rst_n, .module_power_on);
    carrier_model carrier_u (.clk_sys, .supply_stable, .reset_button, .cpu_force,
        .sleep_pull, .system_reset_out, .system_reset_oe, .cpu_reset_out, .cpu_reset_oe,
        .carrier_power_enable, .supply_invalid_n, .system_reset_in_n, .cpu_reset_in_n,
        .sleep_request_n, .rails_on);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task finish_test();
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task chk(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    // 0 pmu, 1 enable, 2 cpu oe, 3 standby, 4 controller reset, 5 block reset
    function automatic logic pick(input int s);
        case (s)
            0: return pmu_power_request;
            1: return carrier_power_enable;
            2: return cpu_reset_oe;
            3: return carrier_standby_n;
            4: return power_controller_rst_n;
            default: return soc_blocks_rst_n;
        endcase
    endfunction

    task wait_for(input int s, input logic v, input int bound);
        waited = 0;
        while (pick(s) !== v)
        begin
            cyc(1);
            waited++;
            if (waited > bound)
            begin
                miscompares++;
                $display("CHECK FAILED %0t timeout on %0d", $time, s);
                finish_test();
            end
        end
    endtask

    task do_reset(input logic strap);
        auto_power_on = strap;
        sys_rst = 1'b1;
        cyc(6);
        sys_rst = 1'b0;
        cyc(4);
    endtask

    task t_reset_vals();
        chk(carrier_power_enable, 1'b0, "enable");
        chk(carrier_standby_n, 1'b1, "standby");
        chk(cpu_reset_oe, 1'b1, "cpu line");
        chk(pmu_power_request, 1'b0, "pmu");
        chk(system_reset_out || cpu_reset_out, 1'b0, "line data");
    endtask

    task t_refused();
        power_button_n = 1'b0;
        cyc(10);
        power_button_n = 1'b1;
        cyc(30);
        chk(pmu_power_request, 1'b0, "bad supply");
    endtask

    task t_power_on();
        supply_stable = 1'b1;
        cyc(10);
        charger_present_n = 1'b0;
        power_button_n = 1'b0;
        cyc(30);
        chk(pmu_power_request, 1'b0, "no rise");
        charger_present_n = 1'b1;
        power_button_n = 1'b1;
        wait_for(0, 1'b1, 40);
        wait_for(1, 1'b1, 20);
        chk(waited == STEP, 1'b1, "enable step");
        chk(system_reset_oe, 1'b1, "sys held");
        wait_for(2, 1'b0, 40);
        chk(system_reset_oe, 1'b0, "sys kept");
        chk(rails_on && module_power_on, 1'b1, "not on");
    endtask

    // one wake kind per pass
    task t_sleep();
        for (int i = 0; i < 3; i++)
        begin
            {sleep_pull, sleep_enter} = (i == 0) ? 2'h2 : 2'h1;
            wait_for(3, 1'b0, 20);
            {sleep_pull, sleep_enter} = 2'h0;
            cyc(10);
            chk(carrier_power_enable, 1'b1, "sleep enable");
            chk(carrier_standby_n, 1'b0, "left sleep");
            case (i)
                0: wake_request = 4'h4;
                1: power_request = 1'b1;
                default: clock_request = 1'b1;
            endcase
            wait_for(3, 1'b1, 20);
            chk(pmu_power_request, 1'b1, "pmu wake");
            {wake_request, power_request, clock_request} = 6'h0;
            cyc(6);
        end
    endtask

    task t_resets();
        primary_chip_reset_n = 1'b0;
        wait_for(4, 1'b0, 10);
        chk(rtc_rst_n || clock_reset_controller_rst_n, 1'b0, "fanout");
        wait_for(5, 1'b0, 10);
        primary_chip_reset_n = 1'b1;
        wait_for(5, 1'b1, 20);
        reset_button = 1'b1;
        wait_for(5, 1'b0, 20);
        reset_button = 1'b0;
        wait_for(5, 1'b1, 20);
        cpu_force = 1'b1;
        wait_for(5, 1'b0, 10);
        chk(power_controller_rst_n && module_power_on, 1'b1, "ctrl hit");
        cpu_force = 1'b0;
        wait_for(5, 1'b1, 20);
    endtask

    task t_shutdown(input logic long_press);
        {power_button_n, shutdown_request} = long_press ? 2'h0 : 2'h3;
        wait_for(2, 1'b1, long_press ? int'(HOLD) + 40 : 10);
        if (long_press)
            chk(waited >= int'(HOLD), 1'b1, "early off");
        shutdown_request = 1'b0;
        chk(carrier_power_enable, 1'b1, "enable first");
        wait_for(1, 1'b0, 20);
        chk(waited == STEP, 1'b1, "drop step");
        wait_for(0, 1'b0, 20);
        chk(waited == STEP, 1'b1, "pmu step");
        cyc(3);
        chk(module_power_on, 1'b0, "not off");
        if (long_press)
        begin
            supply_stable = 1'b0;
            cyc(5);
            power_button_n = 1'b1;
            cyc(30);
            chk(pmu_power_request, 1'b0, "bad supply");
        end
    endtask

    task t_charger();
        do_reset(1'b1);
        supply_stable = 1'b1;
        cyc(10);
        charger_present_n = 1'b0;
        wait_for(2, 1'b0, 80);
        chk(rails_on, 1'b1, "charger on");
        charger_present_n = 1'b1;
    endtask

    initial
    begin
        miscompares = 0;
        comparisons = 0;
        {sys_rst, supply_stable, reset_button, cpu_force, sleep_pull} = 5'h10;
        {power_button_n, charger_present_n, auto_power_on, primary_chip_reset_n} = 4'hd;
        {wake_request, power_request, clock_request, shutdown_request, sleep_enter} = 8'h00;
        do_reset(1'b0);
        t_reset_vals();
        t_refused();
        t_power_on();
        t_sleep();
        t_resets();
        t_shutdown(1'b0);
        t_power_on();
        t_shutdown(1'b1);
        t_charger();
        t_shutdown(1'b0);
        finish_test();
    end
endmodule
